// >>> core/ctsm_access_node.sv
// Access node end: frame classing, channel placement, bearer slots and protection.
//
// Summary of operation
// - Links count one to sixteen, else invalid.
// - Only slots 16, 15, 31 carry communication channels.
// - All other slots except framing slot 0 are on-demand bearer channels.
// - Single link keeps the earlier channel placement.
// - Multi-link runs protection on primary/secondary slot 16.
// - Extra channels: slot 16s, then 15/31 pairs.
// - SAPI 16 goes to packet class.
// - SAPI 32 to 62 goes to frame relay.
// - Any other SAPI goes to signalling class.
// - Control paths start in primary slot 16.
// - Other paths avoid secondary slot 16.
// - Analogue signalling uses exactly one channel.
// - Port classes may share or split channels.
// - One class of a port uses one channel.
// - Multi-slot bearer stays ordered within one link.
// - D-channel frames are multiplexed and relayed.
// - Classes separable, or all but analogue sharing one channel optionally.
// - Control paths survive primary or secondary failure.
// - Bearer protocol offers an allocation audit.
// - Internal failures are reported to the exchange.
// - Both slot 16s form active/standby group one.
`timescale 1ns/1ps
module ctsm_access_node (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [4:0] cfg_links,
   input  wire logic [5:0] cfg_pcc_num,
   input  wire logic       cfg_share_all,
   input  wire logic [5:0] cfg_pkt_lcc,
   input  wire logic [5:0] cfg_fr_lcc,
   input  wire logic [5:0] cfg_sig_lcc,
   input  wire logic [5:0] cfg_analogue_telephony_signalling_lcc,
   input  wire logic       lf_primary,
   input  wire logic       lf_secondary,
   input  wire logic       fr_valid,
   input  wire logic [7:0] fr_addr,
   input  wire logic [7:0] fr_port,
   input  wire logic       fr_analogue_telephony_signalling,
   input  wire logic       int_fail,
   input  wire logic [3:0] int_fail_link,
   input  wire logic [3:0] qry_link,
   input  wire logic [4:0] qry_slot,
   output logic            qry_is_pcc,
   output logic            cfg_err,
   ctsm_if.access_node_side lnk
);

   typedef struct packed {
      logic [15:0][31:0]     alloc;
      logic                  active_sec;
      logic                  df_valid;
      ctsm_pkg::ctsm_class_t df_class;
      logic [5:0]            df_lcc;
      logic [7:0]            df_port;
      logic [7:0]            df_addr;
      logic                  bc_rsp;
      logic                  bc_ok;
      logic [31:0]           bc_map;
      logic                  fail_pulse;
      logic [3:0]            fail_link;
      logic                  cfg_err;
   } ctsm_an_state_t;

   ctsm_an_state_t st_reg;
   ctsm_an_state_t st_next;

   // Rank of a slot in the preferred allocation order; a slot is a channel when
   // its rank lies below the provisioned channel count.
   function automatic logic is_pcc(input logic [3:0] link, input logic [4:0] slot,
                                   input logic [4:0] n, input logic [5:0] num);
      logic [6:0] rank;
      rank = 7'(n) + 7'({link, 1'b0});
      if (5'(link) >= n) begin
         is_pcc = 1'b0;
      end else if (slot == ctsm_pkg::TS_MAIN) begin
         is_pcc = 7'(link) < 7'(num);
      end else if (slot == ctsm_pkg::TS_LOW) begin
         is_pcc = rank < 7'(num);
      end else if (slot == ctsm_pkg::TS_HIGH) begin
         is_pcc = (rank + 7'h01) < 7'(num);
      end else begin
         is_pcc = 1'b0;
      end
   endfunction : is_pcc

   // Channel numbers that stand on the secondary slot 16 are reserved for
   // protection and are folded back onto the primary slot 16.
   function automatic logic [5:0] fix_lcc(input logic [5:0] l, input logic multi);
      fix_lcc = (multi && l == ctsm_pkg::LCC_SEC16) ? ctsm_pkg::LCC_PRI16 : l;
   endfunction : fix_lcc

   logic        cfg_ok;
   logic        multi;
   logic [5:0]  sapi;
   logic [5:0]  span_end;
   logic [31:0] span;
   logic        span_legal;
   logic        span_free;
   logic        span_held;
   logic [3:0]  rlink;

   assign cfg_ok = ctsm_pkg::links_ok(cfg_links);
   assign multi  = cfg_links > ctsm_pkg::MIN_LINKS;
   assign sapi   = fr_addr[ctsm_pkg::SAPI_MSB:ctsm_pkg::SAPI_LSB];
   assign rlink  = lnk.bc_link;
   assign span_end = 6'(lnk.bc_slot) + 6'(lnk.bc_cnt);

   // Mark the requested run of slots on a single link and check each of them;
   // the run is contiguous and ascending, so slot order is kept by construction.
   always_comb begin
      span       = '0;
      span_legal = cfg_ok && (lnk.bc_cnt != '0) && (span_end <= 6'(ctsm_pkg::NSLOTS))
                   && (5'(rlink) < cfg_links);
      span_free  = 1'b1;
      span_held  = 1'b1;
      for (int i = 0; i < ctsm_pkg::NSLOTS; i++) begin
         if (6'(i) >= 6'(lnk.bc_slot) && 6'(i) < span_end) begin
            span[i] = 1'b1;
            if (5'(i) == ctsm_pkg::TS_FRAMING ||
                is_pcc(rlink, 5'(i), cfg_links, cfg_pcc_num)) begin
               span_legal = 1'b0;
            end
            if (st_reg.alloc[rlink][i]) begin
               span_free = 1'b0;
            end else begin
               span_held = 1'b0;
            end
         end
      end
   end

   // Next state: classing, bearer requests, protection switch and failures.
   always_comb begin
      st_next            = st_reg;
      st_next.df_valid   = 1'b0;
      st_next.bc_rsp     = 1'b0;
      st_next.fail_pulse = 1'b0;
      st_next.cfg_err    = !cfg_ok || (multi && (cfg_pkt_lcc == ctsm_pkg::LCC_SEC16 ||
                           cfg_fr_lcc == ctsm_pkg::LCC_SEC16 ||
                           cfg_sig_lcc == ctsm_pkg::LCC_SEC16 ||
                           cfg_analogue_telephony_signalling_lcc == ctsm_pkg::LCC_SEC16));

      // Group one: primary slot 16 is active, the secondary stands by; a failure
      // of the active side moves the control paths only if the other side lives.
      if (!multi) begin
         st_next.active_sec = 1'b0;
      end else if (!st_reg.active_sec && lf_primary && !lf_secondary) begin
         st_next.active_sec = 1'b1;
      end else if (st_reg.active_sec && lf_secondary && !lf_primary) begin
         st_next.active_sec = 1'b0;
      end

      // Frames of every port are multiplexed onto one stream; the channel is
      // chosen per class, so a class of one port never spreads over two.
      if (fr_valid && cfg_ok) begin
         st_next.df_valid = 1'b1;
         st_next.df_port  = fr_port;
         st_next.df_addr  = fr_addr;
         if (fr_analogue_telephony_signalling) begin
            st_next.df_class = ctsm_pkg::CTSM_ANALOGUE_TELEPHONY_SIGNALLING;
            st_next.df_lcc   = fix_lcc(cfg_analogue_telephony_signalling_lcc, multi);
         end else begin
            st_next.df_class = ctsm_pkg::sapi_class(sapi);
            case (ctsm_pkg::sapi_class(sapi))
               ctsm_pkg::CTSM_PACKET: begin
                  st_next.df_lcc = fix_lcc(cfg_pkt_lcc, multi);
               end
               ctsm_pkg::CTSM_FRAME_RELAY: begin
                  st_next.df_lcc = fix_lcc(cfg_fr_lcc, multi);
               end
               default: begin
                  st_next.df_lcc = fix_lcc(cfg_sig_lcc, multi);
               end
            endcase
            if (cfg_share_all) begin
               st_next.df_lcc = fix_lcc(cfg_sig_lcc, multi);
            end
         end
      end

      // Bearer requests are answered on the following cycle.
      if (lnk.bc_req) begin
         st_next.bc_rsp = 1'b1;
         st_next.bc_ok  = 1'b0;
         st_next.bc_map = '0;
         case (lnk.bc_op)
            ctsm_pkg::CTSM_OP_ALLOC: begin
               if (span_legal && span_free) begin
                  st_next.bc_ok        = 1'b1;
                  st_next.alloc[rlink] = st_reg.alloc[rlink] | span;
               end
            end
            ctsm_pkg::CTSM_OP_RELEASE: begin
               if (span_legal && span_held) begin
                  st_next.bc_ok        = 1'b1;
                  st_next.alloc[rlink] = st_reg.alloc[rlink] & ~span;
               end
            end
            ctsm_pkg::CTSM_OP_AUDIT: begin
               if (cfg_ok && 5'(rlink) < cfg_links) begin
                  st_next.bc_ok  = 1'b1;
                  st_next.bc_map = st_reg.alloc[rlink];
               end
            end
            default: begin
               st_next.bc_ok = 1'b0;
            end
         endcase
      end

      // An internal failure drops the link's connections and is reported; it is
      // applied after the bearer request so that it wins over a grant in the same cycle.
      if (int_fail) begin
         st_next.alloc[int_fail_link] = '0;
         st_next.fail_pulse           = 1'b1;
         st_next.fail_link            = int_fail_link;
      end
      if (!cfg_ok) begin
         st_next.alloc = '0;
      end
   end

   // State register.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register except the slot query.
   assign qry_is_pcc     = is_pcc(qry_link, qry_slot, cfg_links, cfg_pcc_num);
   assign cfg_err        = st_reg.cfg_err;
   assign lnk.df_valid   = st_reg.df_valid;
   assign lnk.df_class   = st_reg.df_class;
   assign lnk.df_lcc     = st_reg.df_lcc;
   assign lnk.df_port    = st_reg.df_port;
   assign lnk.df_addr    = st_reg.df_addr;
   assign lnk.bc_rsp     = st_reg.bc_rsp;
   assign lnk.bc_ok      = st_reg.bc_ok;
   assign lnk.bc_map     = st_reg.bc_map;
   assign lnk.fail_pulse = st_reg.fail_pulse;
   assign lnk.fail_link  = st_reg.fail_link;
   assign lnk.prot_sec   = st_reg.active_sec;

endmodule : ctsm_access_node

// >>> inc/ctsm_pkg.sv
// Shared constants, types and decode functions for the timeslot mapper ends.
package ctsm_pkg;
   localparam int          MAX_LINKS   = 16;
   localparam int          LINK_W      = 4;
   localparam int          SLOT_W      = 5;
   localparam int          LCC_W       = 6;
   localparam int          NSLOTS      = 32;
   localparam logic [4:0]  MIN_LINKS   = 5'h01;
   localparam logic [4:0]  TOP_LINKS   = 5'h10;
   localparam logic [4:0]  TS_FRAMING  = 5'h00;
   localparam logic [4:0]  TS_MAIN     = 5'h10;
   localparam logic [4:0]  TS_LOW      = 5'h0F;
   localparam logic [4:0]  TS_HIGH     = 5'h1F;
   localparam logic [3:0]  LINK_PRI    = 4'h0;
   localparam logic [3:0]  LINK_SEC    = 4'h1;
   localparam logic [5:0]  LCC_PRI16   = 6'h00;
   localparam logic [5:0]  LCC_SEC16   = 6'h01;
   localparam logic [5:0]  SAPI_PKT    = 6'h10;
   localparam logic [5:0]  SAPI_FR_LO  = 6'h20;
   localparam logic [5:0]  SAPI_FR_HI  = 6'h3E;
   localparam int          SAPI_MSB    = 7;
   localparam int          SAPI_LSB    = 2;

   typedef enum logic [1:0] {
      CTSM_PACKET, CTSM_FRAME_RELAY, CTSM_SIGNALLING_CLASS, CTSM_ANALOGUE_TELEPHONY_SIGNALLING
   } ctsm_class_t;

   typedef enum logic [1:0] {CTSM_OP_ALLOC, CTSM_OP_RELEASE, CTSM_OP_AUDIT} ctsm_bcop_t;

   // A link count is usable only within one to sixteen.
   function automatic logic links_ok(input logic [4:0] n);
      links_ok = (n >= MIN_LINKS) && (n <= TOP_LINKS);
   endfunction : links_ok

   // Class of a D-channel frame from its SAPI.
   function automatic ctsm_class_t sapi_class(input logic [5:0] sapi);
      if (sapi == SAPI_PKT) begin
         sapi_class = CTSM_PACKET;
      end else if (sapi >= SAPI_FR_LO && sapi <= SAPI_FR_HI) begin
         sapi_class = CTSM_FRAME_RELAY;
      end else begin
         sapi_class = CTSM_SIGNALLING_CLASS;
      end
   endfunction : sapi_class
endpackage : ctsm_pkg

// >>> inc/ctsm_if.sv
// Interface joining the access node end and the exchange end of the mapper.
`timescale 1ns/1ps
interface ctsm_if;
   logic                 df_valid;
   ctsm_pkg::ctsm_class_t df_class;
   logic [5:0]           df_lcc;
   logic [7:0]           df_port;
   logic [7:0]           df_addr;
   logic                 bc_req;
   ctsm_pkg::ctsm_bcop_t bc_op;
   logic [3:0]           bc_link;
   logic [4:0]           bc_slot;
   logic [4:0]           bc_cnt;
   logic                 bc_rsp;
   logic                 bc_ok;
   logic [31:0]          bc_map;
   logic                 fail_pulse;
   logic [3:0]           fail_link;
   logic                 prot_sec;

   modport access_node_side (
      output df_valid, df_class, df_lcc, df_port, df_addr,
      output bc_rsp, bc_ok, bc_map, fail_pulse, fail_link, prot_sec,
      input  bc_req, bc_op, bc_link, bc_slot, bc_cnt
   );
   modport exchange_side (
      input  df_valid, df_class, df_lcc, df_port, df_addr,
      input  bc_rsp, bc_ok, bc_map, fail_pulse, fail_link, prot_sec,
      output bc_req, bc_op, bc_link, bc_slot, bc_cnt
   );
endinterface : ctsm_if

// >>> core/ctsm_exchange.sv
// Exchange end: issues bearer requests, receives relayed frames and failures.
`timescale 1ns/1ps
module ctsm_exchange (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [4:0] cfg_links,
   input  wire logic       rq_valid,
   input  wire logic [1:0] rq_op,
   input  wire logic [3:0] rq_link,
   input  wire logic [4:0] rq_slot,
   input  wire logic [4:0] rq_cnt,
   output logic            rq_ready,
   output logic            an_done,
   output logic            an_ok,
   output logic [31:0]     an_map,
   output logic            rx_valid,
   output logic [1:0]      rx_class,
   output logic [5:0]      rx_lcc,
   output logic [7:0]      rx_port,
   output logic [7:0]      rx_addr,
   output logic            fail_valid,
   output logic [3:0]      fail_link,
   output logic [3:0]      ctl_link,
   output logic            cfg_err,
   ctsm_if.exchange_side   lnk
);

   typedef struct packed {
      logic                 busy;
      logic                 bc_req;
      ctsm_pkg::ctsm_bcop_t bc_op;
      logic [3:0]           bc_link;
      logic [4:0]           bc_slot;
      logic [4:0]           bc_cnt;
      logic                 an_done;
      logic                 an_ok;
      logic [31:0]          an_map;
      logic                 rx_valid;
      logic [1:0]           rx_class;
      logic [5:0]           rx_lcc;
      logic [7:0]           rx_port;
      logic [7:0]           rx_addr;
      logic                 fail_valid;
      logic [3:0]           fail_link;
      logic [3:0]           ctl_link;
   } ctsm_ex_state_t;

   ctsm_ex_state_t st_reg;
   ctsm_ex_state_t st_next;
   logic           cfg_ok;

   assign cfg_ok   = ctsm_pkg::links_ok(cfg_links);
   // One request at a time; an invalid link count refuses all of them.
   assign rq_ready = cfg_ok && !st_reg.busy;

   // Next state: request launch, answer capture and frame delivery.
   always_comb begin
      st_next            = st_reg;
      st_next.bc_req     = 1'b0;
      st_next.an_done    = 1'b0;
      st_next.rx_valid   = 1'b0;
      st_next.fail_valid = 1'b0;
      if (rq_valid && rq_ready) begin
         st_next.busy    = 1'b1;
         st_next.bc_req  = 1'b1;
         st_next.bc_op   = ctsm_pkg::ctsm_bcop_t'(rq_op);
         st_next.bc_link = rq_link;
         st_next.bc_slot = rq_slot;
         st_next.bc_cnt  = rq_cnt;
      end
      if (lnk.bc_rsp && st_reg.busy) begin
         st_next.busy    = 1'b0;
         st_next.an_done = 1'b1;
         st_next.an_ok   = lnk.bc_ok;
         st_next.an_map  = lnk.bc_map;
      end
      if (lnk.df_valid) begin
         st_next.rx_valid = 1'b1;
         st_next.rx_class = 2'(lnk.df_class);
         st_next.rx_lcc   = lnk.df_lcc;
         st_next.rx_port  = lnk.df_port;
         st_next.rx_addr  = lnk.df_addr;
      end
      if (lnk.fail_pulse) begin
         st_next.fail_valid = 1'b1;
         st_next.fail_link  = lnk.fail_link;
      end
      // The control paths follow whichever slot 16 of group one is active.
      st_next.ctl_link = lnk.prot_sec ? ctsm_pkg::LINK_SEC : ctsm_pkg::LINK_PRI;
   end

   // State register.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign lnk.bc_req  = st_reg.bc_req;
   assign lnk.bc_op   = st_reg.bc_op;
   assign lnk.bc_link = st_reg.bc_link;
   assign lnk.bc_slot = st_reg.bc_slot;
   assign lnk.bc_cnt  = st_reg.bc_cnt;
   assign an_done     = st_reg.an_done;
   assign an_ok       = st_reg.an_ok;
   assign an_map      = st_reg.an_map;
   assign rx_valid    = st_reg.rx_valid;
   assign rx_class    = st_reg.rx_class;
   assign rx_lcc      = st_reg.rx_lcc;
   assign rx_port     = st_reg.rx_port;
   assign rx_addr     = st_reg.rx_addr;
   assign fail_valid  = st_reg.fail_valid;
   assign fail_link   = st_reg.fail_link;
   assign ctl_link    = st_reg.ctl_link;
   assign cfg_err     = !cfg_ok;

endmodule : ctsm_exchange

// >>> test/ctsm_assertions.sv
// Concurrent checks on the signals that join the access node end and the exchange end.
`timescale 1ns/1ps
module ctsm_assertions (
   input wire logic                  core_clk,
   input wire logic                  srst,
   input wire logic                  df_valid,
   input wire ctsm_pkg::ctsm_class_t df_class,
   input wire logic [7:0]            df_addr,
   input wire logic                  bc_req,
   input wire ctsm_pkg::ctsm_bcop_t  bc_op,
   input wire logic [3:0]            bc_link,
   input wire logic [4:0]            bc_slot,
   input wire logic                  bc_rsp,
   input wire logic [31:0]           bc_map
);
   // Everything here lives in the one core clock domain.
   default clocking dclk @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // A bearer request is answered by exactly one pulse on the following cycle.
   AST_RSP_NEXT: assert property (bc_req |=> bc_rsp ##1 !bc_rsp)
      else $error("bearer answer did not follow its request by one cycle");
   AST_RSP_CAUSE: assert property (bc_rsp |-> $past(bc_req))
      else $error("bearer answer without a request");
   // Requests are spaced three cycles apart, so the answer cannot be overtaken.
   AST_REQ_GAP: assert property (bc_req |=> !bc_req [*2])
      else $error("bearer requests closer than three cycles");
   AST_REQ_HOLD: assert property (bc_req |=> $stable(bc_link) && $stable(bc_slot))
      else $error("bearer request fields changed before the answer");
   // Class follows the SAPI field of the first address octet; analogue frames are exempt.
   AST_CLASS_PKT: assert property (df_valid && df_class != ctsm_pkg::CTSM_ANALOGUE_TELEPHONY_SIGNALLING
      && df_addr[7:2] == 6'h10 |-> df_class == ctsm_pkg::CTSM_PACKET)
      else $error("packet SAPI not in packet class");
   AST_CLASS_FR: assert property (df_valid && df_class != ctsm_pkg::CTSM_ANALOGUE_TELEPHONY_SIGNALLING
      && df_addr[7:2] >= 6'h20 && df_addr[7:2] <= 6'h3E
      |-> df_class == ctsm_pkg::CTSM_FRAME_RELAY)
      else $error("frame relay SAPI not in frame relay class");
   AST_CLASS_SIG: assert property (df_valid && df_class != ctsm_pkg::CTSM_ANALOGUE_TELEPHONY_SIGNALLING
      && df_addr[7:2] != 6'h10 && (df_addr[7:2] < 6'h20 || df_addr[7:2] > 6'h3E)
      |-> df_class == ctsm_pkg::CTSM_SIGNALLING_CLASS)
      else $error("other SAPI not in signalling class");
   // Slot zero carries framing and may never show up as an allocated bearer.
   AST_NO_FRAMING_SLOT: assert property (bc_rsp |-> !bc_map[0])
      else $error("framing slot reported as bearer");
endmodule : ctsm_assertions

// >>> test/tb_cpath_timeslot_mapper.sv
// Self-checking bench joining both mapper ends and driving their user sides.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
   end \
end
module tb_cpath_timeslot_mapper;
   logic core_clk = 1'b0;
   logic srst, cfg_share_all, lf_primary, lf_secondary, fr_valid, fr_analogue_telephony_signalling, int_fail;
   logic rq_valid, rq_ready, an_done, an_ok, rx_valid, fail_valid, qry_is_pcc;
   logic an_cfg_err, ex_cfg_err;
   logic [4:0]  cfg_links, qry_slot, rq_slot, rq_cnt;
   logic [5:0]  cfg_pcc_num, cfg_pkt_lcc, cfg_fr_lcc, cfg_sig_lcc, cfg_analogue_telephony_signalling_lcc, rx_lcc;
   logic [7:0]  fr_addr, fr_port, rx_port, rx_addr;
   logic [3:0]  int_fail_link, qry_link, rq_link, fail_link, ctl_link;
   logic [1:0]  rq_op, rx_class;
   logic [31:0] an_map;
   int          miscompares = 0;
   int          samples_checked = 0;

   ctsm_if ctsm_if_i ();
   ctsm_access_node ctsm_access_node_i (.core_clk(core_clk), .srst(srst),
      .cfg_links(cfg_links), .cfg_pcc_num(cfg_pcc_num), .cfg_share_all(cfg_share_all),
      .cfg_pkt_lcc(cfg_pkt_lcc), .cfg_fr_lcc(cfg_fr_lcc), .cfg_sig_lcc(cfg_sig_lcc),
      .cfg_analogue_telephony_signalling_lcc(cfg_analogue_telephony_signalling_lcc), .lf_primary(lf_primary), .lf_secondary(lf_secondary),
      .fr_valid(fr_valid), .fr_addr(fr_addr), .fr_port(fr_port), .fr_analogue_telephony_signalling(fr_analogue_telephony_signalling),
      .int_fail(int_fail), .int_fail_link(int_fail_link), .qry_link(qry_link),
      .qry_slot(qry_slot), .qry_is_pcc(qry_is_pcc), .cfg_err(an_cfg_err), .lnk(ctsm_if_i));
   ctsm_exchange ctsm_exchange_i (.core_clk(core_clk), .srst(srst), .cfg_links(cfg_links),
      .rq_valid(rq_valid), .rq_op(rq_op), .rq_link(rq_link), .rq_slot(rq_slot),
      .rq_cnt(rq_cnt), .rq_ready(rq_ready), .an_done(an_done), .an_ok(an_ok),
      .an_map(an_map), .rx_valid(rx_valid), .rx_class(rx_class), .rx_lcc(rx_lcc),
      .rx_port(rx_port), .rx_addr(rx_addr), .fail_valid(fail_valid),
      .fail_link(fail_link), .ctl_link(ctl_link), .cfg_err(ex_cfg_err), .lnk(ctsm_if_i));
   ctsm_assertions ctsm_assertions_i (.core_clk(core_clk), .srst(srst),
      .df_valid(ctsm_if_i.df_valid), .df_class(ctsm_if_i.df_class),
      .df_addr(ctsm_if_i.df_addr), .bc_req(ctsm_if_i.bc_req), .bc_op(ctsm_if_i.bc_op),
      .bc_link(ctsm_if_i.bc_link), .bc_slot(ctsm_if_i.bc_slot),
      .bc_rsp(ctsm_if_i.bc_rsp), .bc_map(ctsm_if_i.bc_map));

   // The 25 MHz core clock.
   always #20 core_clk = ~core_clk;

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic give_up(input string what);
      miscompares++;
      $display("timed out waiting for %s", what);
      report_and_stop();
   endtask : give_up

   // One bearer request; waits for ready and for the answer, both bounded.
   task automatic bc_access(input logic [1:0] op, input logic [3:0] link,
         input logic [4:0] slot, input logic [4:0] cnt, input logic ok, input logic [31:0] map);
      int n;
      n = 0;
      while (rq_ready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 20) give_up("request ready");
      rq_valid = 1'b1;
      rq_op = op;
      rq_link = link;
      rq_slot = slot;
      rq_cnt = cnt;
      @(negedge core_clk);
      rq_valid = 1'b0;
      n = 0;
      while (an_done !== 1'b1 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 10) give_up("bearer answer");
      `CHK("bearer ok", ok, an_ok)
      `CHK("audit map", map, an_map)
   endtask : bc_access

   // One D-channel frame through both ends, checked where the exchange hands it out.
   task automatic send_frame(input logic [7:0] addr, input logic analogue_telephony_signalling,
         input logic [1:0] cls, input logic [5:0] lcc);
      int n;
      fr_valid = 1'b1;
      fr_addr = addr;
      fr_port = addr ^ 8'h5A;
      fr_analogue_telephony_signalling = analogue_telephony_signalling;
      @(negedge core_clk);
      fr_valid = 1'b0;
      n = 0;
      while (rx_valid !== 1'b1 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 8) give_up("relayed frame");
      `CHK("frame class", cls, rx_class)
      `CHK("frame channel", lcc, rx_lcc)
      `CHK("frame port", addr ^ 8'h5A, rx_port)
      `CHK("frame address", addr, rx_addr)
   endtask : send_frame

   task automatic run_frames;
      logic [5:0] sapi [8];
      logic [1:0] cls;
      sapi = '{6'h00, 6'h0F, 6'h10, 6'h11, 6'h1F, 6'h20, 6'h3E, 6'h3F};
      foreach (sapi[i]) begin
         cls = (sapi[i] == 6'h10) ? 2'h0 : (sapi[i] >= 6'h20 && sapi[i] <= 6'h3E) ? 2'h1 : 2'h2;
         send_frame({sapi[i], 2'h2}, 1'b0, cls, 6'h02 + 6'(cls));
      end
      send_frame(8'h42, 1'b1, 2'h3, 6'h05);
      cfg_share_all = 1'b1;
      send_frame(8'h42, 1'b0, 2'h0, 6'h04);
      send_frame(8'h82, 1'b0, 2'h1, 6'h04);
      cfg_share_all = 1'b0;
      // The secondary slot 16 channel is reserved, so it folds back onto channel zero.
      cfg_pkt_lcc = 6'h01;
      send_frame(8'h42, 1'b0, 2'h0, 6'h00);
      `CHK("reserved channel", 1'b1, an_cfg_err)
      cfg_pkt_lcc = 6'h02;
      $display("frame classing test done");
   endtask : run_frames

   // Two links with four channels: slot 16 of both links and slots 15 and 31 of link 0.
   task automatic run_bearer;
      bc_access(2'h0, 4'h0, 5'h01, 5'h0E, 1'b1, 32'h0);
      bc_access(2'h0, 4'h0, 5'h0F, 5'h01, 1'b0, 32'h0);
      bc_access(2'h0, 4'h0, 5'h00, 5'h01, 1'b0, 32'h0);
      bc_access(2'h0, 4'h1, 5'h10, 5'h01, 1'b0, 32'h0);
      bc_access(2'h0, 4'h1, 5'h11, 5'h0F, 1'b1, 32'h0);
      bc_access(2'h0, 4'h0, 5'h11, 5'h10, 1'b0, 32'h0);
      bc_access(2'h0, 4'h0, 5'h05, 5'h01, 1'b0, 32'h0);
      bc_access(2'h2, 4'h0, 5'h00, 5'h00, 1'b1, 32'h00007FFE);
      bc_access(2'h2, 4'h1, 5'h00, 5'h00, 1'b1, 32'hFFFE0000);
      bc_access(2'h2, 4'h2, 5'h00, 5'h00, 1'b0, 32'h0);
      bc_access(2'h1, 4'h0, 5'h01, 5'h0E, 1'b1, 32'h0);
      bc_access(2'h1, 4'h0, 5'h01, 5'h0E, 1'b0, 32'h0);
      bc_access(2'h2, 4'h0, 5'h00, 5'h00, 1'b1, 32'h0);
      int_fail = 1'b1;
      int_fail_link = 4'h1;
      @(negedge core_clk);
      int_fail = 1'b0;
      @(negedge core_clk);
      `CHK("failure report", 1'b1, fail_valid)
      `CHK("failed link", 4'h1, fail_link)
      bc_access(2'h2, 4'h1, 5'h00, 5'h00, 1'b1, 32'h0);
      $display("bearer channel test done");
   endtask : run_bearer

   task automatic run_links;
      logic [9:0] q [6];
      q = '{{1'b1, 4'h0, 5'h10}, {1'b1, 4'h1, 5'h10}, {1'b1, 4'h0, 5'h0F},
            {1'b1, 4'h0, 5'h1F}, {1'b0, 4'h1, 5'h0F}, {1'b0, 4'h0, 5'h05}};
      foreach (q[i]) begin
         qry_link = q[i][8:5];
         qry_slot = q[i][4:0];
         #1 `CHK("channel query", q[i][9], qry_is_pcc)
      end
      @(negedge core_clk);
      lf_primary = 1'b1;
      repeat (2) @(negedge core_clk);
      `CHK("active channel", 1'b1, ctsm_if_i.prot_sec)
      `CHK("control link", 4'h1, ctl_link)
      // A reset in mid-run puts the control paths back on the primary slot 16.
      srst = 1'b1;
      @(negedge core_clk);
      srst = 1'b0;
      `CHK("active after reset", 1'b0, ctsm_if_i.prot_sec)
      `CHK("control after reset", 4'h0, ctl_link)
      repeat (2) @(negedge core_clk);
      `CHK("control link again", 4'h1, ctl_link)
      lf_primary = 1'b0;
      lf_secondary = 1'b1;
      repeat (2) @(negedge core_clk);
      `CHK("control link", 4'h0, ctl_link)
      lf_secondary = 1'b0;
      cfg_links = 5'h01;
      lf_primary = 1'b1;
      repeat (2) @(negedge core_clk);
      `CHK("single link control", 4'h0, ctl_link)
      lf_primary = 1'b0;
      foreach (q[i]) begin
         cfg_links = (i == 0) ? 5'h00 : (i == 1) ? 5'h11 : 5'h10;
         @(negedge core_clk);
         `CHK("exchange link count", i < 2, ex_cfg_err)
         `CHK("node link count", i < 2, an_cfg_err)
      end
      $display("link and protection test done");
   endtask : run_links

   // Reset for ten cycles, then the tests in turn.
   initial begin
      srst = 1'b1;
      {cfg_share_all, lf_primary, lf_secondary, fr_valid, fr_analogue_telephony_signalling, int_fail, rq_valid} = '0;
      {fr_addr, fr_port, int_fail_link, qry_link, qry_slot, rq_op, rq_link, rq_slot} = '0;
      rq_cnt = 5'h00;
      cfg_links = 5'h02;
      cfg_pcc_num = 6'h04;
      cfg_pkt_lcc = 6'h02;
      cfg_fr_lcc = 6'h03;
      cfg_sig_lcc = 6'h04;
      cfg_analogue_telephony_signalling_lcc = 6'h05;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      run_frames();
      run_bearer();
      run_links();
      report_and_stop();
   end
endmodule : tb_cpath_timeslot_mapper
